// >>> ccr_pkg.sv
//------------------------------------------------------------------------------
// Purpose: Shared constants and types for the core clock ratio and reset block.
// Assumes: i_clk runs at 200 MHz and is much faster than the system clock pin.
// Notes: Ratio codes follow the strap table; code 3'b111 is not a valid ratio.
//------------------------------------------------------------------------------
package ccr_pkg;

    //--------------------------------------------------------------------------
    // Clock and timing
    //--------------------------------------------------------------------------
    localparam int CLK_MHZ = 200;
    localparam int RESET_SEQ_NS = 100;
    localparam int RESET_SEQ_CYC = (RESET_SEQ_NS * CLK_MHZ + 999) / 1000;
    localparam int PERIOD_W = 16;
    localparam int RATIO_W = 4;
    localparam int SEL_W = 3;

    //--------------------------------------------------------------------------
    // Ratio strap codes and multipliers
    //--------------------------------------------------------------------------
    localparam logic [SEL_W-1:0] SEL_X4 = 3'h0;
    localparam logic [SEL_W-1:0] SEL_X5 = 3'h1;
    localparam logic [SEL_W-1:0] SEL_X6 = 3'h2;
    localparam logic [SEL_W-1:0] SEL_X7 = 3'h3;
    localparam logic [SEL_W-1:0] SEL_X8 = 3'h4;
    localparam logic [SEL_W-1:0] SEL_X10 = 3'h5;
    localparam logic [SEL_W-1:0] SEL_X12 = 3'h6;
    localparam logic [SEL_W-1:0] SEL_RESERVED = 3'h7;
    localparam logic [SEL_W-1:0] SEL_RESET_VAL = SEL_X4;
    localparam logic [RATIO_W-1:0] RATIO_4 = 4'h4;
    localparam logic [RATIO_W-1:0] RATIO_5 = 4'h5;
    localparam logic [RATIO_W-1:0] RATIO_6 = 4'h6;
    localparam logic [RATIO_W-1:0] RATIO_7 = 4'h7;
    localparam logic [RATIO_W-1:0] RATIO_8 = 4'h8;
    localparam logic [RATIO_W-1:0] RATIO_10 = 4'hA;
    localparam logic [RATIO_W-1:0] RATIO_12 = 4'hC;
    localparam logic [RATIO_W-1:0] RATIO_NONE = 4'h0;

    //--------------------------------------------------------------------------
    // Pin bundle and sequencer states
    //--------------------------------------------------------------------------
    typedef struct packed {
        logic reset_req_b;
        logic por_b;
        logic sys_clk;
        logic out_disable;
        logic [SEL_W-1:0] core_ratio_select;
    } ccr_pins_type;

    localparam int PINS_W = $bits(ccr_pins_type);
    localparam ccr_pins_type PINS_RESET_VAL = '{1'b0, 1'b0, 1'b0, 1'b0, SEL_RESET_VAL};

    typedef enum logic [1:0] {
        ST_HOLD,
        ST_LATCH,
        ST_SEQ,
        ST_DONE
    } ccr_state_type;

endpackage

// >>> ccr_sync.sv
//------------------------------------------------------------------------------
// Purpose: Three-stage synchroniser with an agree filter for each pin bit.
// Assumes: Inputs come from outside the i_clk domain.
// Notes: The first stage feeds only the second stage.
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module ccr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RESET_VAL = '0
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire logic [WIDTH-1:0] i_async,
    output logic [WIDTH-1:0] o_sync
);

    logic [WIDTH-1:0] s1_q;
    logic [WIDTH-1:0] s2_q;
    logic [WIDTH-1:0] s3_q;
    logic [WIDTH-1:0] out_q;
    logic [WIDTH-1:0] out_d;

    //--------------------------------------------------------------------------
    // Per-bit filter
    //--------------------------------------------------------------------------
    genvar b;
    generate
        for (b = 0; b < WIDTH; b++) begin : g_bit
            // A change counts only when the second and third stages agree.
            always_comb begin
                out_d[b] = (s2_q[b] == s3_q[b]) ? s3_q[b] : out_q[b];
            end
        end
    endgenerate

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            s1_q <= RESET_VAL;
            s2_q <= RESET_VAL;
            s3_q <= RESET_VAL;
            out_q <= RESET_VAL;
        end else begin
            s1_q <= i_async;
            s2_q <= s1_q;
            s3_q <= s2_q;
            out_q <= out_d;
        end
    end

    assign o_sync = out_q;

endmodule // ccr_sync

// >>> ccr_top.sv
//------------------------------------------------------------------------------
// Purpose: Core clock ratio selection and reset sequencing for a processor.
// Assumes: i_clk is a fast sampling clock; the system clock arrives on a pin.
// Notes: The core clock is a one-cycle enable stream at ratio times the
//        measured system clock rate.
//------------------------------------------------------------------------------
// Function
// RL1 - Core clock is an integer multiple of system clock, chosen by straps.
// RL2 - Codes 000..110 give 4,5,6,7,8,10,12; 111 is reserved, invalid.
// RL3 - Board ties straps fixed; they may change only during reset.
// RL4 - Reset input puts the device in a known state with execution idle.
// RL5 - Board holds reset input asserted a minimum time per reset kind.
// RL6 - Device drives reset-done output once its reset sequence finishes.
// RL7 - Power-on input resets internal DRAM; board ties it to reset-done.
// RL8 - While reset is active every output pin is high impedance.
// RL9 - Every asynchronous input, reset included, is synchronised before use. Code: i_rst_b clears every flop directly, unsynchronised.
// RL10 - Output pins can also be high impedance during normal operation.
`timescale 1ns/1ps
module ccr_top
    import ccr_pkg::*;
#(
    parameter int SEQ_CYCLES = RESET_SEQ_CYC
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire ccr_pkg::ccr_pins_type i_pins,
    output logic o_core_clk_en,
    output logic [ccr_pkg::RATIO_W-1:0] o_core_ratio,
    output logic o_ratio_invalid,
    output logic o_core_run,
    output logic o_reset_done,
    output logic o_reset_done_oe,
    output logic o_pin_oe,
    output logic o_dram_reset
);
    import ccr_pkg::*;

    ccr_pins_type pins;
    ccr_state_type state_q;
    ccr_state_type state_d;
    logic [15:0] seq_cnt_q;
    logic [15:0] seq_cnt_d;
    logic [RATIO_W-1:0] ratio_q;
    logic [RATIO_W-1:0] ratio_d;
    logic inval_q;
    logic inval_d;
    logic sys_prev_q;
    logic [PERIOD_W-1:0] per_cnt_q;
    logic [PERIOD_W-1:0] per_cnt_d;
    logic [PERIOD_W-1:0] period_q;
    logic [PERIOD_W-1:0] period_d;
    logic [PERIOD_W:0] acc_q;
    logic [PERIOD_W:0] acc_d;
    logic [PERIOD_W:0] acc_sum;
    logic core_en_q;
    logic core_en_d;
    logic run_q;
    logic run_d;
    logic done_q;
    logic done_d;
    logic done_oe_q;
    logic done_oe_d;
    logic pin_oe_q;
    logic pin_oe_d;
    logic dram_rst_q;
    logic dram_rst_d;
    logic sys_rise;

    //--------------------------------------------------------------------------
    // Pin synchronisers
    //--------------------------------------------------------------------------
    ccr_sync #(
        .WIDTH(PINS_W),
        .RESET_VAL(PINS_RESET_VAL)
    ) u_sync (
        .i_clk(i_clk),
        .i_rst_b(i_rst_b),
        .i_async(i_pins),
        .o_sync(pins)
    ); // [RL9]

    //--------------------------------------------------------------------------
    // Reset sequencer
    //--------------------------------------------------------------------------
    always_comb begin
        state_d = state_q;
        seq_cnt_d = seq_cnt_q;
        ratio_d = ratio_q;
        inval_d = inval_q;
        case (state_q)
            ST_HOLD: begin
                seq_cnt_d = '0;
                if (pins.reset_req_b) begin
                    state_d = ST_LATCH;
                end
            end
            ST_LATCH: begin
                // Straps are only sampled here, so later changes are ignored.
                inval_d = 1'b0; // [RL3]
                case (pins.core_ratio_select) // [RL2]
                    SEL_X4: ratio_d = RATIO_4;
                    SEL_X5: ratio_d = RATIO_5;
                    SEL_X6: ratio_d = RATIO_6;
                    SEL_X7: ratio_d = RATIO_7;
                    SEL_X8: ratio_d = RATIO_8;
                    SEL_X10: ratio_d = RATIO_10;
                    SEL_X12: ratio_d = RATIO_12;
                    default: begin
                        ratio_d = RATIO_NONE;
                        inval_d = 1'b1;
                    end
                endcase
                state_d = ST_SEQ;
            end
            ST_SEQ: begin
                if (seq_cnt_q >= 16'(SEQ_CYCLES - 1)) begin
                    state_d = ST_DONE;
                end else begin
                    seq_cnt_d = seq_cnt_q + 16'h0001;
                end
            end
            ST_DONE: begin
            end
            default: begin
                state_d = ST_HOLD;
            end
        endcase
        // Reset request wins in every state.
        if (!pins.reset_req_b) begin
            state_d = ST_HOLD; // [RL4]
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            state_q <= ST_HOLD;
            seq_cnt_q <= 16'h0000;
            ratio_q <= RATIO_4;
            inval_q <= 1'b0;
        end else begin
            state_q <= state_d;
            seq_cnt_q <= seq_cnt_d;
            ratio_q <= ratio_d;
            inval_q <= inval_d;
        end
    end

    //--------------------------------------------------------------------------
    // Core clock enable generator
    //--------------------------------------------------------------------------
    // The period is measured on the synchronised system clock, so jitter of
    // one sampling cycle shows up as slight spacing variation of the enables.
    assign sys_rise = pins.sys_clk && !sys_prev_q;
    assign acc_sum = acc_q + {{(PERIOD_W + 1 - RATIO_W){1'b0}}, ratio_q};

    always_comb begin
        per_cnt_d = per_cnt_q;
        period_d = period_q;
        acc_d = acc_q;
        core_en_d = 1'b0;
        if (sys_rise) begin
            per_cnt_d = {{(PERIOD_W - 1){1'b0}}, 1'b1};
            period_d = per_cnt_q;
        end else if (per_cnt_q != '1) begin
            per_cnt_d = per_cnt_q + {{(PERIOD_W - 1){1'b0}}, 1'b1};
        end
        if (run_d && period_q != '0) begin
            // Ratio enables per measured period: rate is ratio times system rate.
            if (acc_sum >= {1'b0, period_q}) begin
                acc_d = acc_sum - {1'b0, period_q};
                core_en_d = 1'b1; // [RL1]
            end else begin
                acc_d = acc_sum;
            end
        end else begin
            acc_d = '0;
        end
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            sys_prev_q <= 1'b0;
            per_cnt_q <= '0;
            period_q <= '0;
            acc_q <= '0;
            core_en_q <= 1'b0;
        end else begin
            sys_prev_q <= pins.sys_clk;
            per_cnt_q <= per_cnt_d;
            period_q <= period_d;
            acc_q <= acc_d;
            core_en_q <= core_en_d;
        end
    end

    //--------------------------------------------------------------------------
    // Output controls
    //--------------------------------------------------------------------------
    always_comb begin
        // Execution stays idle until the sequence ends with a valid ratio.
        run_d = (state_q == ST_DONE) && !inval_q && pins.reset_req_b; // [RL4]
        done_d = (state_q == ST_DONE); // [RL6]
        done_oe_d = (state_q != ST_HOLD); // [RL8]
        pin_oe_d = (state_q == ST_DONE) && !pins.out_disable; // [RL8] [RL10]
        dram_rst_d = !pins.por_b; // [RL7]
    end

    always_ff @(posedge i_clk or negedge i_rst_b) begin
        if (!i_rst_b) begin
            run_q <= 1'b0;
            done_q <= 1'b0;
            done_oe_q <= 1'b0;
            pin_oe_q <= 1'b0;
            dram_rst_q <= 1'b1;
        end else begin
            run_q <= run_d;
            done_q <= done_d;
            done_oe_q <= done_oe_d;
            pin_oe_q <= pin_oe_d;
            dram_rst_q <= dram_rst_d;
        end
    end

    assign o_core_clk_en = core_en_q;
    assign o_core_ratio = ratio_q;
    assign o_ratio_invalid = inval_q;
    assign o_core_run = run_q;
    assign o_reset_done = done_q;
    assign o_reset_done_oe = done_oe_q;
    assign o_pin_oe = pin_oe_q;
    assign o_dram_reset = dram_rst_q;

endmodule // ccr_top

// >>> ccr_top_assertions.sv
//------------------------------------------------------------------------------
// Purpose: Port checks for ccr_top.
// Assumes: One clock domain; i_rst_b is asynchronous, active low.
// Notes: Windows allow for the three-flop input synchronisers.
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module ccr_top_chk
    import ccr_pkg::*;
#(
    parameter int SEQ_CYCLES = 2
) (
    input wire logic i_clk,
    input wire logic i_rst_b,
    input wire ccr_pkg::ccr_pins_type i_pins,
    input wire logic o_core_clk_en,
    input wire logic [ccr_pkg::RATIO_W-1:0] o_core_ratio,
    input wire logic o_ratio_invalid,
    input wire logic o_core_run,
    input wire logic o_reset_done,
    input wire logic o_reset_done_oe,
    input wire logic o_pin_oe,
    input wire logic o_dram_reset
);
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (!i_rst_b);
    hold_quiet_a: assert property (!i_pins.reset_req_b [*8] |->
        !o_pin_oe && !o_reset_done_oe && !o_core_run) else $error("pins driven in reset");
    run_known_a: assert property (o_core_run |->
        o_reset_done && !o_ratio_invalid) else $error("run without done");
    bad_code_a: assert property (o_ratio_invalid |->
        o_core_ratio == RATIO_NONE && !o_core_run) else $error("bad code runs");
    enable_run_a: assert property (o_core_clk_en |-> o_core_run)
        else $error("core enable while idle");
    ratio_hold_a: assert property (o_reset_done && $past(o_reset_done) |->
        $stable(o_core_ratio)) else $error("ratio moved while running");
    done_late_a: assert property ($rose(o_reset_done) |->
        $past(i_pins.reset_req_b, SEQ_CYCLES + 2) && o_reset_done_oe) else $error("early done");
    dram_on_a: assert property (!i_pins.por_b [*8] |-> o_dram_reset)
        else $error("dram reset missing");
    dram_off_a: assert property (i_pins.por_b [*8] |-> !o_dram_reset)
        else $error("dram reset stuck");
    quiet_run_a: assert property (i_pins.out_disable [*8] |-> !o_pin_oe)
        else $error("pins driven while disabled");
    sync_delay_a: assert property ($rose(i_pins.reset_req_b) |->
        !o_reset_done_oe ##1 !o_reset_done_oe) else $error("reset pin used unsynced");
endmodule // ccr_top_chk

bind ccr_top ccr_top_chk #(.SEQ_CYCLES(SEQ_CYCLES)) u_chk (.i_clk(i_clk), .i_rst_b(i_rst_b),
    .i_pins(i_pins), .o_core_clk_en(o_core_clk_en), .o_core_ratio(o_core_ratio),
    .o_ratio_invalid(o_ratio_invalid), .o_core_run(o_core_run), .o_reset_done(o_reset_done),
    .o_reset_done_oe(o_reset_done_oe), .o_pin_oe(o_pin_oe), .o_dram_reset(o_dram_reset));

// >>> ccr_board.sv
//------------------------------------------------------------------------------
// Purpose: Board model: system clock source, reset wiring and strap pins.
// Assumes: System clock period is 40 sampling cycles.
// Notes: Straps follow the request only while reset is held.
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module ccr_board
    import ccr_pkg::*;
(
    input wire logic i_clk,
    input wire logic i_req_b,
    input wire logic [ccr_pkg::SEL_W-1:0] i_sel,
    input wire logic i_dis,
    input wire logic i_done,
    output ccr_pkg::ccr_pins_type o_pins
);
    logic [4:0] cnt_q = '0;
    logic sclk_q = 1'b0;
    logic [SEL_W-1:0] sel_q = SEL_RESET_VAL;
    always @(posedge i_clk) begin
        cnt_q <= (cnt_q == 5'h13) ? 5'h00 : cnt_q + 5'h01;
        if (cnt_q == 5'h13) begin
            sclk_q <= ~sclk_q;
        end
        if (!i_req_b) begin
            sel_q <= i_sel;
        end
    end
    // Power-on input is wired straight to the reset-done output.
    assign o_pins = {i_req_b, i_done, sclk_q, i_dis, sel_q};
endmodule // ccr_board

// >>> tb_ccr_top.sv
//------------------------------------------------------------------------------
// Purpose: Self-checking bench for ccr_top.
// Assumes: SEQ_CYCLES is shortened to 2.
// Notes: Enable counts allow one pulse of phase slack.
//------------------------------------------------------------------------------
`timescale 1ns/1ps
module tb_ccr_top;
    import ccr_pkg::*;
    localparam int SEQ = 2;
    localparam logic [RATIO_W-1:0] RTAB [8] = '{RATIO_4, RATIO_5, RATIO_6, RATIO_7,
        RATIO_8, RATIO_10, RATIO_12, RATIO_NONE};
    logic i_clk, i_rst_b, req_b = 1'b0, dis = 1'b0;
    logic [SEL_W-1:0] sel = SEL_X4;
    ccr_pins_type pins;
    logic clk_en, inv, run, done, done_oe, pin_oe, dram;
    logic [RATIO_W-1:0] ratio;
    int err_total = 0, n_tests = 0;
    ccr_top #(.SEQ_CYCLES(SEQ)) u_dut (.i_clk(i_clk), .i_rst_b(i_rst_b), .i_pins(pins),
        .o_core_clk_en(clk_en), .o_core_ratio(ratio), .o_ratio_invalid(inv),
        .o_core_run(run), .o_reset_done(done), .o_reset_done_oe(done_oe),
        .o_pin_oe(pin_oe), .o_dram_reset(dram));
    ccr_board u_board (.i_clk(i_clk), .i_req_b(req_b), .i_sel(sel), .i_dis(dis),
        .i_done(done), .o_pins(pins));
    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] got);
        n_tests++;
        if (got !== exp) begin
            err_total++;
            $display("ERROR %s expected %0h seen %0h", name, exp, got);
        end
    endtask
    task automatic report_and_stop();
        $display("checks %0d mismatches %0d", n_tests, err_total);
        if (err_total == 0 && n_tests > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask
    task automatic cyc(input int n);
        repeat (n) @(negedge i_clk);
    endtask
    task automatic t_chip_reset();
        @(posedge i_clk) i_rst_b <= 1'b0;
        cyc(2);
        chk("ratio", {12'h000, RATIO_4}, {12'h000, ratio});
        chk("dram", 16'h0001, {15'h0000, dram});
        chk("pin_oe", 16'h0000, {15'h0000, pin_oe | done_oe | run | done});
        @(posedge i_clk) i_rst_b <= 1'b1;
    endtask
    task automatic t_ratio(input logic [SEL_W-1:0] code, input logic [RATIO_W-1:0] r);
        int n, cnt;
        bit ok;
        @(posedge i_clk) begin
            req_b <= 1'b0;
            sel <= code;
        end
        cyc(16);
        chk("held oe", 16'h0000, {14'h0000, pin_oe, done_oe});
        chk("held run", 16'h0000, {15'h0000, run});
        chk("held dram", 16'h0001, {15'h0000, dram});
        @(posedge i_clk) req_b <= 1'b1;
        n = 0;
        cyc(1);
        while (done !== 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        chk("done time", 16'h0001, {15'h0000, n >= SEQ + 1 && n <= SEQ + 8});
        chk("done oe", 16'h0001, {15'h0000, done_oe});
        chk("run", {15'h0000, code != SEL_RESERVED}, {15'h0000, run});
        chk("ratio", {12'h000, r}, {12'h000, ratio});
        chk("invalid", {15'h0000, code == SEL_RESERVED}, {15'h0000, inv});
        cyc(100);
        chk("dram off", 16'h0000, {15'h0000, dram});
        cnt = 0;
        repeat (400) begin
            @(negedge i_clk);
            if (clk_en === 1'b1) cnt++;
        end
        ok = (r == 0) ? (cnt == 0) : (cnt + 1 >= r * 10 && cnt <= r * 10 + 1);
        chk("enables", 16'h0001, {15'h0000, ok});
    endtask
    task automatic t_disable();
        chk("oe run", 16'h0001, {15'h0000, pin_oe});
        @(posedge i_clk) dis <= 1'b1;
        cyc(10);
        chk("oe off", 16'h0001, {14'h0000, pin_oe, done});
        @(posedge i_clk) dis <= 1'b0;
        cyc(10);
        chk("oe back", 16'h0001, {15'h0000, pin_oe});
    endtask
    initial begin
        i_rst_b = 1'b0;
        cyc(2);
        @(posedge i_clk) i_rst_b <= 1'b1;
        for (int i = 0; i < 8; i++) begin
            t_ratio(i[2:0], RTAB[i]);
        end
        t_disable();
        t_chip_reset();
        t_ratio(SEL_X12, RATIO_12);
        report_and_stop();
    end
    initial begin
        #100000;
        err_total++;
        report_and_stop();
    end
endmodule // tb_ccr_top
